// ===== drre_pkg.sv
// Function
// R1: moves data between two address-map locations in the background, no processor.
// R2: sixteen channels, each enabled or disabled on its own.
// R3: thirty-two hardware request lines trigger channels.
// R4: request assignment registers pick the line that triggers each channel.
// R5: after reset channel n follows request line n.
// R6: software keeps only one source of a shared line enabled.
// R7: all transfers go through one 64-bit memory master port.
// R8: transfer data is buffered in a four-entry, 64-bit wide FIFO.
// R9: element width selectable as 8, 16, 32 or 64 bits.
// R10: source and destination addresses fixed, incremented or offset.
// R11: per-channel control held in parity-protected RAM; corruption detected.
// R12: transfers start from a hardware line or a software request.
// R13: accesses are checked against four programmable protection regions.
// R14: line 12 shares timer compare 0; other compares on lines 13, 18, 19.
// R15: line 10 is shared by converter group 1, two-wire receive, serial buffer.
// R16: chaining triggers another channel at completion; auto-init restarts from initial packet.
// R17: frame done, last frame start, half block and block done interrupts.
package drre_pkg;
  localparam int NCH        = 16;
  localparam int NLINE      = 32;
  localparam int NREGION    = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int RAM_DEPTH  = 32;
  localparam logic [4:0] WORK_BASE      = 5'h10;
  localparam logic [4:0] LINE_OS_TIMER0 = 5'h0C;
  localparam logic [4:0] LINE_CONV_G1   = 5'h0A;
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_LAST  = 1;
  localparam int IRQ_HALF  = 2;
  localparam int IRQ_BLOCK = 3;

  typedef enum logic [1:0] {
    AM_FIXED = 2'b00,
    AM_INC   = 2'b01,
    AM_OFFS  = 2'b10
  } drre_amode_t;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [7:0]  elems;
    logic [7:0]  frames;
    logic [1:0]  esize;
    drre_amode_t smode;
    drre_amode_t dmode;
    logic [15:0] soff;
    logic [15:0] doff;
    logic        chain_en;
    logic [3:0]  chain_ch;
    logic        auto_init;
    logic [3:0]  irq_en;
  } drre_pkt_t;

  typedef struct packed {
    logic        en;
    logic [31:0] lo;
    logic [31:0] hi;
  } drre_region_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic [7:0]  be;
  } drre_mreq_t;

  typedef struct packed {
    logic frame_done_irq;
    logic last_frame_start_irq;
    logic half_block_irq;
    logic block_done_irq;
  } drre_irq_t;
endpackage

// ===== drre_ctl_ram.sv
`timescale 1ns/1ps
`default_nettype none
module drre_ctl_ram
  import drre_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int W     = 128
) (
  // clock
  input  wire logic                     mclk_in,
  // access port
  input  wire logic                     we_in,
  input  wire logic [$clog2(DEPTH)-1:0] addr_in,
  input  wire logic [W-1:0]             wdata_in,
  output logic      [W:0]               rdata_out
);
  logic [W:0] mem [DEPTH];

  // even parity kept beside each entry
  always_ff @(posedge mclk_in) begin
    if (we_in) begin
      mem[addr_in] <= {^wdata_in, wdata_in}; // see R11
    end
  end

  always_ff @(posedge mclk_in) begin
    rdata_out <= mem[addr_in];
  end
endmodule // drre_ctl_ram
`default_nettype wire

// ===== drre_engine.sv
`timescale 1ns/1ps
`default_nettype none
module drre_engine
  import drre_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                        mclk_in,
  input  wire logic                        rst_n_in,
  // triggers and enables
  input  wire logic [NLINE-1:0]            hw_request_line_in,
  input  wire logic [NCH-1:0]              sw_req_in,
  input  wire logic [NCH-1:0]              chan_en_in,
  // control packet and request assignment
  input  wire logic                        cfg_we_in,
  input  wire logic [3:0]                  cfg_ch_in,
  input  wire drre_pkt_t                   cfg_pkt_in,
  output logic                             cfg_ready_out,
  input  wire logic                        assign_we_in,
  input  wire logic [3:0]                  assign_ch_in,
  input  wire logic [4:0]                  assign_line_in,
  input  wire drre_region_t [NREGION-1:0]  mpu_region_in,
  // memory master port
  output drre_mreq_t                       mem_out,
  input  wire logic                        mem_ack_in,
  input  wire logic [63:0]                 mem_rdata_in,
  // events and status
  output drre_irq_t                        irq_out,
  output logic [3:0]                       irq_ch_out,
  output logic                             parity_err_out,
  output logic                             mpu_err_out,
  output logic                             busy_out,
  output logic [3:0]                       active_ch_out
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_CHK  = 3'b010,
    ST_RD   = 3'b011,
    ST_WR   = 3'b100,
    ST_WB   = 3'b101
  } drre_state_t;

  localparam int PW = $clog2(DEPTH);

  function automatic logic [7:0] be_mask(logic [1:0] sz, logic [2:0] lo);
    logic [7:0] m;
    case (sz)
      2'b00:   m = 8'h01;
      2'b01:   m = 8'h03;
      2'b10:   m = 8'h0F;
      default: m = 8'hFF;
    endcase
    return 8'(m << lo);
  endfunction

  function automatic logic [31:0] adv(logic [31:0] a, drre_amode_t md,
                                      logic [1:0] sz, logic [15:0] off);
    case (md)
      AM_INC:  return 32'(a + (32'h1 << sz)); // see R10
      AM_OFFS: return 32'(a + {16'h0000, off}); // see R10
      default: return a;
    endcase
  endfunction

  function automatic logic mpu_ok(logic [31:0] a,
                                  drre_region_t [NREGION-1:0] r);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < NREGION; i++) begin
      if (r[i].en && a >= r[i].lo && a <= r[i].hi) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  function automatic logic [63:0] sz_mask(logic [1:0] sz);
    logic [63:0] m;
    case (sz)
      2'b00:   m = 64'h0000_0000_0000_00FF;
      2'b01:   m = 64'h0000_0000_0000_FFFF;
      2'b10:   m = 64'h0000_0000_FFFF_FFFF;
      default: m = 64'hFFFF_FFFF_FFFF_FFFF;
    endcase
    return m;
  endfunction

  drre_state_t     state;
  drre_pkt_t       cur;
  logic [4:0]      assign_map [NCH];
  logic [NLINE-1:0] line_q;
  logic [NCH-1:0]  pend;
  logic [NCH-1:0]  wvalid;
  logic [NCH-1:0]  halted;
  logic [7:0]      total [NCH];
  logic [7:0]      rd_left;
  logic [7:0]      wr_left;
  logic [3:0]      ch;
  logic            from_init;
  logic            ram_we;
  logic [4:0]      ram_addr;
  drre_pkt_t       ram_wdata;
  logic [128:0]    ram_rdata;
  drre_pkt_t       ram_pkt;
  logic [63:0]     fifo [DEPTH];
  logic [PW-1:0]   wp;
  logic [PW-1:0]   rp;
  logic [PW:0]     fcnt;
  logic            cfg_take;
  logic            start_go;
  logic [3:0]      start_ch;
  logic [NCH-1:0]  trig;
  logic [NCH-1:0]  chain_set;
  logic [7:0]      next_frames;

  drre_ctl_ram #(.DEPTH(RAM_DEPTH), .W(128)) u_ram (
    .mclk_in   (mclk_in),
    .we_in     (ram_we),
    .addr_in   (ram_addr),
    .wdata_in  (ram_wdata),
    .rdata_out (ram_rdata)
  );

  assign ram_pkt = drre_pkt_t'(ram_rdata[127:0]);

  // default identity pairing; software may repoint any channel
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NCH; i++) begin
        assign_map[i] <= 5'(i); // see R5
      end
    end else if (assign_we_in) begin
      assign_map[assign_ch_in] <= assign_line_in; // see R4
    end
  end

  // shared lines (10, 12, ...) arrive already merged; only a rising edge triggers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      line_q <= '0;
    end else begin
      line_q <= hw_request_line_in; // see R3, R14, R15
    end
  end

  always_comb begin
    cfg_take = cfg_we_in && cfg_ready_out;
    start_go = (state == ST_IDLE) && !cfg_take && (|(pend & chan_en_in));
    start_ch = 4'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pend[i] && chan_en_in[i]) begin
        start_ch = 4'(i);
      end
    end
    for (int i = 0; i < NCH; i++) begin
      trig[i] = (hw_request_line_in[assign_map[i]] &&
                 !line_q[assign_map[i]]) || sw_req_in[i]; // see R12
    end
    next_frames = 8'(cur.frames - 8'h01);
    chain_set = '0;
    if (state == ST_WR && wr_left == 8'h00 && next_frames == 8'h00 &&
        cur.chain_en) begin
      chain_set[cur.chain_ch] = 1'b1; // see R16
    end
  end

  // a trigger in the same cycle as service start is kept
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pend <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!chan_en_in[i] || halted[i]) begin
          pend[i] <= 1'b0; // see R2
        end else if (trig[i] || chain_set[i]) begin
          pend[i] <= 1'b1;
        end else if (start_go && start_ch == 4'(i)) begin
          pend[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      cur <= '0;
      ch <= 4'h0;
      from_init <= 1'b0;
      rd_left <= 8'h00;
      wr_left <= 8'h00;
      wvalid <= '0;
      halted <= '0;
      for (int i = 0; i < NCH; i++) begin
        total[i] <= 8'h00;
      end
      ram_we <= 1'b0;
      ram_addr <= 5'h00;
      ram_wdata <= '0;
      wp <= '0;
      rp <= '0;
      fcnt <= '0;
      mem_out <= '0;
      irq_out <= '0;
      irq_ch_out <= 4'h0;
      parity_err_out <= 1'b0;
      mpu_err_out <= 1'b0;
      busy_out <= 1'b0;
      active_ch_out <= 4'h0;
      cfg_ready_out <= 1'b1;
    end else begin
      ram_we <= 1'b0;
      irq_out <= '0;
      parity_err_out <= 1'b0;
      mpu_err_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cfg_take) begin
            ram_we <= 1'b1;
            ram_addr <= {1'b0, cfg_ch_in};
            ram_wdata <= cfg_pkt_in;
            wvalid[cfg_ch_in] <= 1'b0;
            halted[cfg_ch_in] <= 1'b0;
          end else if (start_go) begin
            // resume mid-block from the working copy, else the initial one
            ch <= start_ch;
            from_init <= !wvalid[start_ch];
            ram_addr <= wvalid[start_ch] ? (WORK_BASE | 5'(start_ch))
                                         : {1'b0, start_ch}; // see R16
            state <= ST_WAIT;
            busy_out <= 1'b1;
            active_ch_out <= start_ch;
            cfg_ready_out <= 1'b0;
          end
        end
        ST_WAIT: begin
          state <= ST_CHK;
        end
        ST_CHK: begin
          cur <= ram_pkt;
          rd_left <= ram_pkt.elems;
          wr_left <= ram_pkt.elems;
          if (^ram_rdata) begin
            parity_err_out <= 1'b1; // see R11
            wvalid[ch] <= 1'b0;
            state <= ST_IDLE;
          end else if (ram_pkt.frames == 8'h00 ||
                       ram_pkt.elems == 8'h00) begin
            state <= ST_IDLE;
          end else begin
            if (from_init) begin
              total[ch] <= ram_pkt.frames;
            end
            irq_out.last_frame_start_irq <=
              ram_pkt.frames == 8'h01 && ram_pkt.irq_en[IRQ_LAST]; // see R17
            irq_ch_out <= ch;
            state <= ST_RD;
          end
        end
        ST_RD: begin
          if (mem_out.req) begin
            if (mem_ack_in) begin
              mem_out.req <= 1'b0;
              wp <= PW'(wp + 1'b1);
              fcnt <= (PW+1)'(fcnt + 1'b1);
              rd_left <= 8'(rd_left - 8'h01);
              cur.src <= adv(cur.src, cur.smode, cur.esize, cur.soff);
            end
          end else if (rd_left == 8'h00 || fcnt == (PW+1)'(DEPTH)) begin
            state <= ST_WR;
          end else if (!mpu_ok(cur.src, mpu_region_in)) begin
            mpu_err_out <= 1'b1; // see R13
            wvalid[ch] <= 1'b0;
            wp <= '0;
            rp <= '0;
            fcnt <= '0;
            state <= ST_IDLE;
          end else begin
            mem_out.req <= 1'b1; // see R1, R7
            mem_out.we <= 1'b0;
            mem_out.addr <= {cur.src[31:3], 3'b000};
            mem_out.be <= be_mask(cur.esize, cur.src[2:0]); // see R9
          end
        end
        ST_WR: begin
          if (mem_out.req) begin
            if (mem_ack_in) begin
              mem_out.req <= 1'b0;
              mem_out.we <= 1'b0;
              rp <= PW'(rp + 1'b1);
              fcnt <= (PW+1)'(fcnt - 1'b1);
              wr_left <= 8'(wr_left - 8'h01);
              cur.dst <= adv(cur.dst, cur.dmode, cur.esize, cur.doff);
            end
          end else if (wr_left == 8'h00) begin
            // frame over: advance frame count and report progress
            cur.frames <= next_frames;
            irq_ch_out <= ch;
            irq_out.frame_done_irq <= cur.irq_en[IRQ_FRAME]; // see R17
            irq_out.half_block_irq <= cur.irq_en[IRQ_HALF] &&
                                      next_frames == (total[ch] >> 1);
            irq_out.block_done_irq <= cur.irq_en[IRQ_BLOCK] &&
                                      next_frames == 8'h00;
            ram_we <= 1'b1;
            ram_addr <= WORK_BASE | 5'(ch);
            ram_wdata <= cur;
            ram_wdata.frames <= next_frames;
            wvalid[ch] <= next_frames != 8'h00;
            halted[ch] <= next_frames == 8'h00 && !cur.auto_init; // see R16
            state <= ST_WB;
          end else if (fcnt == '0) begin
            state <= ST_RD;
          end else if (!mpu_ok(cur.dst, mpu_region_in)) begin
            mpu_err_out <= 1'b1; // see R13
            wvalid[ch] <= 1'b0;
            wp <= '0;
            rp <= '0;
            fcnt <= '0;
            state <= ST_IDLE;
          end else begin
            mem_out.req <= 1'b1; // see R7
            mem_out.we <= 1'b1;
            mem_out.addr <= {cur.dst[31:3], 3'b000};
            mem_out.be <= be_mask(cur.esize, cur.dst[2:0]); // see R9
            mem_out.wdata <= 64'((fifo[rp] & sz_mask(cur.esize)) <<
                                 {cur.dst[2:0], 3'b000});
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (state != ST_IDLE && state != ST_WAIT && state != ST_CHK &&
          state != ST_RD && state != ST_WR) begin
        busy_out <= 1'b0;
        cfg_ready_out <= 1'b1;
      end else if (state == ST_CHK && (^ram_rdata ||
                   ram_pkt.frames == 8'h00 ||
                   ram_pkt.elems == 8'h00)) begin
        busy_out <= 1'b0;
        cfg_ready_out <= 1'b1;
      end else if ((state == ST_RD || state == ST_WR) && !mem_out.req &&
                   !mpu_ok(state == ST_RD ? cur.src : cur.dst, mpu_region_in)
                   && !(state == ST_RD && (rd_left == 8'h00 ||
                        fcnt == (PW+1)'(DEPTH)))
                   && !(state == ST_WR && (wr_left == 8'h00 ||
                        fcnt == '0))) begin
        busy_out <= 1'b0;
        cfg_ready_out <= 1'b1;
      end
    end
  end

  // fifo words need no reset, so they stay out of the reset process
  always_ff @(posedge mclk_in) begin
    if (state == ST_RD && mem_out.req && mem_ack_in) begin
      fifo[wp] <= (mem_rdata_in >> {cur.src[2:0], 3'b000}) &
                  sz_mask(cur.esize); // see R8
    end
  end

  // checks
  logic assign_touched;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      assign_touched <= 1'b0;
    end else if (assign_we_in) begin
      assign_touched <= 1'b1;
    end
  end

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_bus_wait;
    mem_out.req && !mem_ack_in;
  endsequence

  chk_assign_identity: assert property (!assign_touched |->
    assign_map[3] == 5'h03 && assign_map[12] == LINE_OS_TIMER0) // see R5
    else $error("request pairing not identity after reset");
  chk_we_has_req: assert property (mem_out.we |-> mem_out.req) // see R7
    else $error("write strobe without bus request");
  chk_bus_hold: assert property (s_bus_wait |=>
    mem_out.req && $stable(mem_out.addr) && $stable(mem_out.be)) // see R1
    else $error("bus request dropped before acknowledge");
  chk_fifo_bound: assert property (fcnt <= (PW+1)'(DEPTH)) // see R8
    else $error("fifo count beyond depth");
  chk_be_size: assert property (mem_out.req |->
    $countones(mem_out.be) == (1 << cur.esize)) // see R9
    else $error("byte enables disagree with element size");
  chk_fixed_src: assert property (state == ST_RD && mem_out.req &&
    mem_ack_in && cur.smode == AM_FIXED |=> $stable(cur.src)) // see R10
    else $error("fixed source address moved");
  chk_parity_drop: assert property (state == ST_CHK && ^ram_rdata |=>
    parity_err_out && state == ST_IDLE) // see R11
    else $error("corrupt control entry not flagged");
  chk_mpu_ok: assert property ($rose(mem_out.req) |->
    mpu_ok(mem_out.addr, mpu_region_in) ||
    mpu_ok(mem_out.we ? cur.dst : cur.src, mpu_region_in)) // see R13
    else $error("access issued outside protection regions");
  chk_start_enabled: assert property (start_go |->
    chan_en_in[start_ch] ##1 state == ST_WAIT) // see R2
    else $error("disabled channel started");
  chk_sw_pend: assert property (sw_req_in[5] &&
    chan_en_in[5] && !halted[5] |=> pend[5]) // see R12
    else $error("software request lost");
endmodule // drre_engine
`default_nettype wire

// ===== drre_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module drre_mem_model
  import drre_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  // memory master port, far side
  input  wire drre_mreq_t  mem_in,
  input  wire logic [3:0]  lat_in,
  output logic             ack_out,
  output logic [63:0]      rdata_out
);
  logic [63:0] ram [0:511];
  logic [3:0]  cnt;
  logic [63:0] last;
  logic [8:0]  idx;

  assign idx = mem_in.addr[11:3];

  // ack after lat_in extra cycles; one-cycle pulse
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      cnt     <= 4'h0;
    end else if (ack_out) begin
      ack_out <= 1'b0;
      cnt     <= 4'h0;
    end else if (mem_in.req) begin
      if (cnt >= lat_in) ack_out <= 1'b1;
      else cnt <= cnt + 4'h1;
    end
  end

  // byte lanes written only where enabled
  always @(posedge mclk_in) begin
    if (ack_out && mem_in.req && mem_in.we) begin
      for (int b = 0; b < 8; b++) begin
        if (mem_in.be[b]) ram[idx][b*8+:8] <= mem_in.wdata[b*8+:8];
      end
    end
    if (ack_out) last <= rdata_out;
  end

  // outside the ack cycle the data lines carry junk, not stale data
  assign rdata_out = ack_out ? ram[idx] : ~last;
endmodule // drre_mem_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import drre_pkg::*;
  logic                       mclk_in = 1'b0;
  logic                       rst_n_in = 1'b0;
  logic [NLINE-1:0]           line = '0;
  logic [NCH-1:0]             sw_req = '0;
  logic [NCH-1:0]             chan_en = '1;
  logic                       cfg_we = 1'b0;
  logic [3:0]                 cfg_ch = 4'h0;
  drre_pkt_t                  cfg_pkt = '0;
  logic                       cfg_ready;
  logic                       asg_we = 1'b0;
  logic [3:0]                 asg_ch = 4'h0;
  logic [4:0]                 asg_line = 5'h00;
  drre_region_t [NREGION-1:0] region = '0;
  drre_mreq_t                 mreq;
  logic                       ack;
  logic [63:0]                rdata;
  drre_irq_t                  irq;
  logic                       par_err;
  logic                       mpu_err;
  logic                       busy;
  logic [3:0]                 lat = 4'h0;
  int                         errors = 0;
  int                         checks_done = 0;
  int                         n_block;
  int                         n_frame;
  logic                       saw_busy;
  logic                       saw_mpu;
  int                         n_last;
  logic                       saw_par;
  logic [3:0]                 irq_ch;
  logic [3:0]                 act_ch;
  logic [3:0]                 done_ch;
  logic [3:0]                 busy_ch;

  always #10 mclk_in = ~mclk_in;

  drre_engine #(.DEPTH(FIFO_DEPTH)) uut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .hw_request_line_in(line), .sw_req_in(sw_req), .chan_en_in(chan_en),
    .cfg_we_in(cfg_we), .cfg_ch_in(cfg_ch), .cfg_pkt_in(cfg_pkt),
    .cfg_ready_out(cfg_ready), .assign_we_in(asg_we),
    .assign_ch_in(asg_ch), .assign_line_in(asg_line),
    .mpu_region_in(region), .mem_out(mreq), .mem_ack_in(ack),
    .mem_rdata_in(rdata), .irq_out(irq), .irq_ch_out(irq_ch),
    .parity_err_out(par_err), .mpu_err_out(mpu_err), .busy_out(busy),
    .active_ch_out(act_ch)
  );

  drre_mem_model mem (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .mem_in(mreq),
    .lat_in(lat), .ack_out(ack), .rdata_out(rdata)
  );

  // one-cycle pulses are easy to miss, so they are tallied here
  always @(posedge mclk_in) begin
    n_block  += int'(irq.block_done_irq === 1'b1);
    n_frame  += int'(irq.frame_done_irq === 1'b1);
    saw_busy |= (busy === 1'b1);
    saw_mpu  |= (mpu_err === 1'b1);
    n_last   += int'(irq.last_frame_start_irq === 1'b1);
    saw_par  |= (par_err === 1'b1);
    if (irq.block_done_irq === 1'b1) done_ch = irq_ch;
    if (busy === 1'b1) busy_ch = act_ch;
  end

  task automatic wrap_up();
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic drre_pkt_t mk(logic [31:0] s, logic [31:0] d,
                                   logic [1:0] sz);
    drre_pkt_t p;
    p        = '0;
    p.src    = s;
    p.dst    = d;
    p.elems  = 8'h01;
    p.frames = 8'h01;
    p.esize  = sz;
    p.smode  = AM_INC;
    p.dmode  = AM_INC;
    p.irq_en = 4'hF;
    return p;
  endfunction

  task automatic cfg(logic [3:0] ch, drre_pkt_t p);
    check("cfg_ready", {63'h0, cfg_ready}, 64'h1);
    @(posedge mclk_in);
    cfg_we  <= 1'b1;
    cfg_ch  <= ch;
    cfg_pkt <= p;
    @(posedge mclk_in);
    cfg_we  <= 1'b0;
  endtask

  task automatic clear();
    @(negedge mclk_in);
    n_block  = 0;
    n_frame  = 0;
    saw_busy = 1'b0;
    saw_mpu  = 1'b0;
    n_last   = 0;
    saw_par  = 1'b0;
  endtask

  // hw selects a request line, else a software request of that channel
  task automatic trig(bit hw, int idx, bit expect_run);
    int i;
    clear();
    @(posedge mclk_in);
    if (hw) line[idx] <= 1'b1;
    else sw_req[idx] <= 1'b1;
    @(posedge mclk_in);
    sw_req <= '0;
    repeat (2) @(posedge mclk_in);
    line <= '0;
    if (!expect_run) begin
      repeat (30) @(posedge mclk_in);
      check("no_service", {63'h0, saw_busy}, 64'h0);
      return;
    end
    for (i = 0; i < 400 && (!saw_busy || busy !== 1'b0); i++) begin
      @(posedge mclk_in);
    end
    if (i == 400) begin
      errors++;
      $display("ERROR busy_out expected 0 seen stuck");
      wrap_up();
    end
    repeat (2) @(posedge mclk_in);
  endtask

  // one element, source in the top lane, destination in lane 0
  task automatic xfer(logic [3:0] ch, logic [1:0] sz);
    logic [31:0] s;
    logic [31:0] d;
    logic [63:0] sw;
    logic [63:0] exp;
    int          n;
    n  = 1 << sz;
    s  = 32'h0000_0100 + 32'(8 - n);
    d  = 32'h0000_0200 + 32'(ch) * 32'h8;
    sw = 64'h8877_6655_4433_2211 ^ {16{sz, ch[1:0]}};
    mem.ram[s[11:3]] = sw;
    mem.ram[d[11:3]] = 64'hFFFF_FFFF_FFFF_FFFF;
    exp = 64'hFFFF_FFFF_FFFF_FFFF;
    for (int b = 0; b < n; b++) exp[b*8+:8] = sw[(8-n+b)*8+:8];
    cfg(ch, mk(s, d, sz));
    trig(1'b0, int'(ch), 1'b1);
    check("dst_word", mem.ram[d[11:3]], exp);
    check("block_done", 64'(n_block), 64'h1);
    check("frame_done", 64'(n_frame), 64'h1);
    check("last_frame", 64'(n_last), 64'h1);
    check("irq_ch", 64'(done_ch), 64'(ch));
    check("active_ch", 64'(busy_ch), 64'(ch));
  endtask

  // default map, then line reassignment including shared lines
  task automatic hw_map();
    // channels 10 and 12 also follow lines 10 and 12 but hold no packet
    chan_en[10] <= 1'b0;
    chan_en[12] <= 1'b0;
    cfg(4'h3, mk(32'h100, 32'h300, 2'h2));
    trig(1'b1, 3, 1'b1);
    check("done_on_line3", 64'(n_block), 64'h1);
    cfg(4'h3, mk(32'h100, 32'h300, 2'h2));
    @(posedge mclk_in);
    asg_we   <= 1'b1;
    asg_ch   <= 4'h3;
    asg_line <= LINE_OS_TIMER0;
    @(posedge mclk_in);
    asg_ch   <= 4'h4;
    asg_line <= LINE_CONV_G1;
    @(posedge mclk_in);
    asg_we   <= 1'b0;
    trig(1'b1, 3, 1'b0);
    trig(1'b1, int'(LINE_OS_TIMER0), 1'b1);
    check("done_on_line12", 64'(n_block), 64'h1);
    cfg(4'h4, mk(32'h100, 32'h308, 2'h1));
    trig(1'b1, int'(LINE_CONV_G1), 1'b1);
    check("done_on_line10", 64'(n_block), 64'h1);
  endtask

  task automatic misc();
    chan_en[2] <= 1'b0;
    cfg(4'h2, mk(32'h100, 32'h310, 2'h0));
    trig(1'b0, 2, 1'b0);
    chan_en[2] <= 1'b1;
    cfg(4'h7, mk(32'h0001_0000, 32'h318, 2'h3));
    trig(1'b0, 7, 1'b1);
    check("mpu_err", {63'h0, saw_mpu}, 64'h1);
    cfg(4'h6, mk(32'h100, 32'h320, 2'h2));
    cfg_pkt.chain_en <= 1'b1;
    cfg(4'h5, '{src: 32'h100, dst: 32'h328, elems: 8'h01, frames: 8'h01,
                esize: 2'h2, smode: AM_INC, dmode: AM_INC, soff: 16'h0,
                doff: 16'h0, chain_en: 1'b1, chain_ch: 4'h6,
                auto_init: 1'b0, irq_en: 4'hF});
    trig(1'b0, 5, 1'b1);
    repeat (60) @(posedge mclk_in);
    check("chain_blocks", 64'(n_block), 64'h2);
  endtask

  // fixed source word lands at two offset destinations
  task automatic modes();
    drre_pkt_t p;
    p       = mk(32'h140, 32'h340, 2'h2);
    p.elems = 8'h02;
    p.smode = AM_FIXED;
    p.dmode = AM_OFFS;
    p.doff  = 16'h0010;
    mem.ram[9'h028] = 64'hA5A5_A5A5_1234_5678;
    mem.ram[9'h068] = 64'hFFFF_FFFF_FFFF_FFFF;
    mem.ram[9'h06A] = 64'hFFFF_FFFF_FFFF_FFFF;
    cfg(4'h9, p);
    trig(1'b0, 9, 1'b1);
    check("offs_dst0", mem.ram[9'h068], 64'hFFFF_FFFF_1234_5678);
    check("offs_dst1", mem.ram[9'h06A], 64'hFFFF_FFFF_1234_5678);
  endtask

  // one flipped bit in a stored packet must drop the work
  task automatic par_bad();
    cfg(4'h8, mk(32'h100, 32'h360, 2'h2));
    repeat (2) @(negedge mclk_in);
    uut.u_ram.mem[8][100] = ~uut.u_ram.mem[8][100];
    trig(1'b0, 8, 1'b1);
    check("parity_err", {63'h0, saw_par}, 64'h1);
    check("par_no_block", 64'(n_block), 64'h0);
  endtask

  initial begin
    region[0] <= '{en: 1'b1, lo: 32'h0, hi: 32'h0000_0FFF};
    repeat (8) @(posedge mclk_in);
    check("ready_in_reset", {63'h0, cfg_ready}, 64'h1);
    check("busy_in_reset", {63'h0, busy}, 64'h0);
    @(posedge mclk_in);
    rst_n_in <= 1'b1;
    for (int z = 0; z < 4; z++) xfer(4'(z), 2'(z));
    lat <= 4'h3;
    xfer(4'hF, 2'h3);
    lat <= 4'h0;
    hw_map();
    misc();
    modes();
    par_bad();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
